// >>> logic/video_deserializer_config_regs.sv
// configuration and status register bank of a serial video receiver
// assumes an APB master on CLK_SYS, datapath status on the same clock,
// and a multifunction port whose inputs arrive asynchronously
//
// Notes on behaviour
// R1: read-only CRC flags; combined drives pin 5
// R2: CRC replace read/write, zero, never on pins
// R3: three 5-bit EDH flag groups, read-only
// R4: three flag-error summaries, pin-assignable outputs
// R5: EDH enable one, force zero, pin inputs
// R6: checksum force read/write input; checksum error output
// R7: FIFO empty reads one after reset, pin 6
// R8: FIFO 90%, full, overrun read-only outputs
// R9: 16-bit packet identifier resets to 0000h
// R10: 16-bit identifier mask resets to ffffh
// R11: message/FIFO controls zero; extract enable pin input
// R12: message available, short message read-only outputs
// R13: 3-bit video FIFO depth resets to zero
// R14: forced format zero; SD/HD only zero
// R15: format, H, V, F read-only on pins 3..0
// R16: sync position, SAV, EAV outputs; EAV pin 7
// R17: framing mode, enable one; enable pin input
// R18: descramble, NRZI, clip, sync enables reset one
// R19: both de-dither enables zero, pin inputs
// R20: lock on pin 4; unscramble, ext clock zero
// R21: pattern select zero; enables zero; pass read-only
// R22: reference clock select zero; 48-bit pin config
// R23: host toggles port clock thrice after reset
// R24: host writes address then data per clock
// R25: reset restores defaults; manual reset active high
// R26: assigned pin inputs override; outputs track status
//
// Added by the designer: the placing of the registers and register access over APB.
`default_nettype none
module video_deserializer_config_regs (
  // system
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic MAN_RESET,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cfgbank_pkg::APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // datapath
  input wire cfgbank_pkg::stat_s STATUS_IN,
  output cfgbank_pkg::ctrl_s CTRL_OUT,
  // multifunction port
  input wire logic [7:0] MIO_IN,
  output logic [7:0] MIO_OUT,
  output logic [7:0] MIO_OE_B
);
  import cfgbank_pkg::*;

  state_s q;
  state_s d;
  logic [7:0] idx;
  logic [8:0] rd;
  logic addr_ok;
  logic wr_take;
  ctrl_s eff;

  // ----------------------------------------------------------------
  // read decode: {mapped, byte}
  // ----------------------------------------------------------------
  function automatic logic [8:0] rd_reg(logic [7:0] i, ctrl_s c, stat_s s,
                                        logic [NPIN*PCFG_W-1:0] pc);
    logic [8:0] r;
    r = {1'b1, 8'h00};
    case (i)
      REG_EDH0: r[7:0] = {s.crc_err, c.edh_force, c.edh_enable, s.ff_flags};
      REG_EDH1: r[7:0] = {c.crc_replace, s.crc_err_luma, s.crc_err_chroma, s.ap_flags};
      REG_EDH2: r[7:0] = {s.ff_flag_err, s.ap_flag_err, s.anc_flag_err, s.anc_flags};
      REG_ANC0: r[7:0] = {c.vfifo_depth, s.fifo_overrun, s.fifo_empty, s.fifo_full,
                          s.cksum_err, c.cksum_force};
      REG_ANC1: r[7:0] = c.anc_id[7:0];
      REG_ANC2: r[7:0] = c.anc_id[15:8];
      REG_ANC3: r[7:0] = c.anc_mask[7:0];
      REG_ANC4: r[7:0] = c.anc_mask[15:8];
      REG_ANC5: r[7:0] = {c.fifo_extract_en, c.fifo_clk_en, s.full_msg_avail, 1'b0,
                          c.fifo_flush_static, 1'b0, c.msg_flush_static, c.message_tracking};
      REG_ANC6: r[7:0] = {s.fifo_90, s.short_msg, 6'h00};
      REG_FMT0: r[7:0] = {c.framing_mode, c.sd_only, c.hd_only, c.format_set};
      REG_FMT1: r[7:0] = {s.f, s.v, s.h, s.format};
      REG_TEST0: r[7:0] = {s.pass_fail, c.tpg_en, c.tpg_sel};
      REG_VINFO0: r[7:0] = {c.sync_detect_en, c.lsb_clip_en, c.nrzi_en, c.descramble_en,
                            c.vdither_en, c.hdither_en, c.bar_filter_enable, s.lock};
      REG_VINFO1: r[7:0] = {s.eav, s.sav, s.new_sync_position, c.ref_clk_sel,
                            c.ext_vclk, c.unscrambled_out, c.framing_enable};
      default: begin
        if (i[7:3] == REG_PIN0[7:3]) begin
          r[7:0] = {2'b00, pc[int'(i[2:0])*PCFG_W +: PCFG_W]};
        end else begin
          r = 9'h000;
        end
      end
    endcase
    return r;
  endfunction : rd_reg

  // ----------------------------------------------------------------
  // status bit routed to an output pin
  // ----------------------------------------------------------------
  function automatic logic out_sel(logic [4:0] code, stat_s s);
    logic b;
    b = 1'b0;
    case (code)
      OSEL_F: b = s.f; // R15
      OSEL_V: b = s.v;
      OSEL_H: b = s.h;
      OSEL_FMT4: b = s.format[4];
      OSEL_LOCK: b = s.lock; // R20
      OSEL_CRC: b = s.crc_err; // R1
      OSEL_EMPTY: b = s.fifo_empty; // R7
      OSEL_EAV: b = s.eav; // R16
      OSEL_LUMA: b = s.crc_err_luma;
      OSEL_CHROMA: b = s.crc_err_chroma;
      OSEL_FFERR: b = s.ff_flag_err; // R4
      OSEL_APERR: b = s.ap_flag_err;
      OSEL_ANCERR: b = s.anc_flag_err;
      OSEL_CKSUM: b = s.cksum_err; // R6
      OSEL_F90: b = s.fifo_90; // R8
      OSEL_FULL: b = s.fifo_full;
      OSEL_OVR: b = s.fifo_overrun;
      OSEL_MSG: b = s.full_msg_avail; // R12
      OSEL_SHORT: b = s.short_msg;
      OSEL_NSP: b = s.new_sync_position;
      OSEL_SAV: b = s.sav;
      OSEL_PASS: b = s.pass_fail; // R21
      default: b = 1'b0;
    endcase
    return b;
  endfunction : out_sel

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    idx = PADDR[9:2];
    rd = rd_reg(idx, q.cfg, q.stat, q.pincfg);
    addr_ok = rd[8] && (PADDR[1:0] == 2'b00);
    wr_take = PSEL && PENABLE && q.pready && PWRITE && addr_ok;
    // pins are asynchronous: two stages before use
    d.mio_s1 = MIO_IN;
    d.mio_s2 = q.mio_s1;
    d.mrst_s1 = MAN_RESET;
    d.mrst_s2 = q.mrst_s1;
    d.stat = STATUS_IN; // R3 R8 R12 R15 R16
    // one wait state, so the read byte comes from a flop
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    if (PSEL && PENABLE && !q.pready) begin
      d.pready = 1'b1;
      d.pslverr = !addr_ok;
      d.prdata = (PWRITE || !addr_ok) ? 32'h0000_0000 : {24'h00_0000, rd[7:0]};
    end
    // read-only bits of a written register are left alone
    if (wr_take) begin
      case (idx)
        REG_EDH0: {d.cfg.edh_force, d.cfg.edh_enable} = PWDATA[6:5]; // R5
        REG_EDH1: d.cfg.crc_replace = PWDATA[7]; // R2
        REG_ANC0: begin
          d.cfg.vfifo_depth = PWDATA[7:5]; // R13
          d.cfg.cksum_force = PWDATA[0]; // R6
        end
        REG_ANC1: d.cfg.anc_id[7:0] = PWDATA[7:0]; // R9
        REG_ANC2: d.cfg.anc_id[15:8] = PWDATA[7:0];
        REG_ANC3: d.cfg.anc_mask[7:0] = PWDATA[7:0]; // R10
        REG_ANC4: d.cfg.anc_mask[15:8] = PWDATA[7:0];
        REG_ANC5: begin
          {d.cfg.fifo_extract_en, d.cfg.fifo_clk_en} = PWDATA[7:6]; // R11
          d.cfg.fifo_flush_static = PWDATA[3];
          {d.cfg.msg_flush_static, d.cfg.message_tracking} = PWDATA[1:0];
        end
        REG_FMT0: {d.cfg.framing_mode, d.cfg.sd_only, d.cfg.hd_only,
                   d.cfg.format_set} = PWDATA[7:0]; // R14 R17
        REG_TEST0: {d.cfg.tpg_en, d.cfg.tpg_sel} = PWDATA[6:0]; // R21
        REG_VINFO0: {d.cfg.sync_detect_en, d.cfg.lsb_clip_en, d.cfg.nrzi_en,
                     d.cfg.descramble_en, d.cfg.vdither_en, d.cfg.hdither_en,
                     d.cfg.bar_filter_enable} = PWDATA[7:1]; // R18 R19
        REG_VINFO1: {d.cfg.ref_clk_sel, d.cfg.ext_vclk, d.cfg.unscrambled_out,
                     d.cfg.framing_enable} = PWDATA[4:0]; // R20 R22
        default: begin
          if (idx[7:3] == REG_PIN0[7:3]) begin
            d.pincfg[int'(idx[2:0])*PCFG_W +: PCFG_W] = PWDATA[PCFG_W-1:0]; // R22
          end
        end
      endcase
    end
    // pins assigned as inputs override the stored control
    eff = q.cfg;
    for (int p = 0; p < NPIN; p++) begin
      if (q.pincfg[p*PCFG_W+PCFG_DIR]) begin
        case (q.pincfg[p*PCFG_W +: 5])
          ISEL_EDH_FORCE: eff.edh_force = q.mio_s2[p]; // R26 R5
          ISEL_EDH_EN: eff.edh_enable = q.mio_s2[p];
          ISEL_CKSUM_FORCE: eff.cksum_force = q.mio_s2[p]; // R6
          ISEL_EXTRACT: eff.fifo_extract_en = q.mio_s2[p]; // R11
          ISEL_FRAMING: eff.framing_enable = q.mio_s2[p]; // R17
          ISEL_HDITHER: eff.hdither_en = q.mio_s2[p]; // R19
          ISEL_VDITHER: eff.vdither_en = q.mio_s2[p];
          ISEL_TPG_EN: eff.tpg_en = q.mio_s2[p];
          ISEL_BAR_FILT: eff.bar_filter_enable = q.mio_s2[p];
          default: eff.tpg_en = eff.tpg_en;
        endcase
      end
      d.mio_out[p] = out_sel(q.pincfg[p*PCFG_W +: 5], q.stat); // R26
      d.mio_oe_b[p] = q.pincfg[p*PCFG_W+PCFG_DIR];
    end
    d.ctl_out = eff;
    // manual reset restores the control, pin config and status defaults, not the APB response
    if (q.mrst_s2) begin
      d.cfg = CTRL_RST; // R25
      d.pincfg = PINCFG_RST; // R1 R7 R15 R16 R20
      d.stat = STAT_RST; // R7
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      q <= STATE_RST; // R25
    end else begin
      q <= d;
    end
  end

  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign CTRL_OUT = q.ctl_out;
  assign MIO_OUT = q.mio_out;
  assign MIO_OE_B = q.mio_oe_b;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  property p_empty_after_reset;
    q.mrst_s2 |=> q.stat.fifo_empty && !q.stat.fifo_full && q.pincfg[41:36] == 6'h06
      ##1 MIO_OUT[6];
  endproperty
  a_empty_after_reset: assert property (p_empty_after_reset) // R7
    else $error("fifo empty not set after manual reset");

  property p_crc_cleared;
    q.mrst_s2 |=> !q.stat.crc_err && !q.stat.crc_err_luma && !q.stat.crc_err_chroma;
  endproperty
  a_crc_cleared: assert property (p_crc_cleared) // R1
    else $error("crc flags not cleared by manual reset");

  property p_defaults;
    q.mrst_s2 |=> q.cfg.anc_mask == 16'hffff && q.cfg.anc_id == 16'h0000
      && q.cfg.edh_enable && !q.cfg.edh_force && q.cfg.ref_clk_sel == 2'b00;
  endproperty
  a_defaults: assert property (p_defaults) // R10
    else $error("control defaults wrong after manual reset");

  property p_enables_one;
    q.mrst_s2 |=> ##1 CTRL_OUT.descramble_en && CTRL_OUT.nrzi_en && CTRL_OUT.lsb_clip_en
      && CTRL_OUT.sync_detect_en && CTRL_OUT.framing_mode;
  endproperty
  a_enables_one: assert property (p_enables_one) // R18
    else $error("decode enables not set after manual reset");

  property p_id_write;
    PSEL && PENABLE && PWRITE && q.pready && !q.mrst_s2 && PADDR == {REG_ANC1, 2'b00}
      |=> q.cfg.anc_id[7:0] == $past(PWDATA[7:0]);
  endproperty
  a_id_write: assert property (p_id_write) // R9
    else $error("identifier low byte not written");

  property p_depth_write;
    PSEL && PENABLE && PWRITE && q.pready && !q.mrst_s2 && PADDR == {REG_ANC0, 2'b00}
      |=> q.cfg.vfifo_depth == $past(PWDATA[7:5]) ##1 CTRL_OUT.vfifo_depth == q.cfg.vfifo_depth;
  endproperty
  a_depth_write: assert property (p_depth_write) // R13
    else $error("video fifo depth not written");

  property p_apb_answer;
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY;
  endproperty
  a_apb_answer: assert property (p_apb_answer) // R24
    else $error("apb answer not one cycle after access");

  property p_pin0_framing;
    q.pincfg[5:0] == {1'b1, ISEL_FRAMING} && !q.mrst_s2
      |=> CTRL_OUT.framing_enable == $past(q.mio_s2[0]) && MIO_OE_B[0];
  endproperty
  a_pin0_framing: assert property (p_pin0_framing) // R17
    else $error("pin input does not override framing enable");

  property p_pin0_output;
    !q.pincfg[5] && q.pincfg[4:0] == OSEL_F |=> MIO_OUT[0] == $past(q.stat.f) && !MIO_OE_B[0];
  endproperty
  a_pin0_output: assert property (p_pin0_output) // R15
    else $error("pin 0 does not follow frame bit");

  c_write: cover property (PSEL && PENABLE && PREADY && PWRITE && !PSLVERR);
  c_read: cover property (PSEL && PENABLE && PREADY && !PWRITE && PRDATA != 32'h0);
  c_error: cover property (PSEL && PENABLE && PREADY && PSLVERR);
  c_pin_in: cover property (MIO_OE_B != 8'h00);
endmodule : video_deserializer_config_regs
`default_nettype wire

// >>> shared/cfgbank_pkg.sv
// constants, types and reset values of the video receiver configuration bank
// assumes an APB master with 32-bit data and byte addresses
`default_nettype none
package cfgbank_pkg;
  localparam int APB_AW = 10;
  localparam int NPIN = 8;
  localparam int PCFG_W = 6;
  // pin config bit: 1 = pin is an input, 0 = pin is driven
  localparam int PCFG_DIR = 5;
  // register indices; byte address is four times the index
  localparam logic [7:0] REG_EDH0 = 8'h01;
  localparam logic [7:0] REG_EDH1 = 8'h02;
  localparam logic [7:0] REG_EDH2 = 8'h03;
  localparam logic [7:0] REG_ANC0 = 8'h04;
  localparam logic [7:0] REG_ANC1 = 8'h05;
  localparam logic [7:0] REG_ANC2 = 8'h06;
  localparam logic [7:0] REG_ANC3 = 8'h07;
  localparam logic [7:0] REG_ANC4 = 8'h08;
  localparam logic [7:0] REG_FMT0 = 8'h0b;
  localparam logic [7:0] REG_FMT1 = 8'h0c;
  localparam logic [7:0] REG_TEST0 = 8'h0d;
  localparam logic [7:0] REG_VINFO0 = 8'h0e;
  localparam logic [7:0] REG_VINFO1 = 8'h0f;
  localparam logic [7:0] REG_ANC5 = 8'h17;
  localparam logic [7:0] REG_ANC6 = 8'h18;
  // eight pin config registers, one per pin
  localparam logic [7:0] REG_PIN0 = 8'h20;

  typedef enum logic [4:0] {
    OSEL_F = 5'h00, OSEL_V = 5'h01, OSEL_H = 5'h02, OSEL_FMT4 = 5'h03,
    OSEL_LOCK = 5'h04, OSEL_CRC = 5'h05, OSEL_EMPTY = 5'h06, OSEL_EAV = 5'h07,
    OSEL_LUMA = 5'h08, OSEL_CHROMA = 5'h09, OSEL_FFERR = 5'h0a, OSEL_APERR = 5'h0b,
    OSEL_ANCERR = 5'h0c, OSEL_CKSUM = 5'h0d, OSEL_F90 = 5'h0e, OSEL_FULL = 5'h0f,
    OSEL_OVR = 5'h10, OSEL_MSG = 5'h11, OSEL_SHORT = 5'h12, OSEL_NSP = 5'h13,
    OSEL_SAV = 5'h14, OSEL_PASS = 5'h15
  } osel_e;

  typedef enum logic [4:0] {
    ISEL_EDH_FORCE = 5'h00, ISEL_EDH_EN = 5'h01, ISEL_CKSUM_FORCE = 5'h02,
    ISEL_EXTRACT = 5'h03, ISEL_FRAMING = 5'h04, ISEL_HDITHER = 5'h05,
    ISEL_VDITHER = 5'h06, ISEL_TPG_EN = 5'h07, ISEL_BAR_FILT = 5'h08
  } isel_e;

  typedef struct packed {
    logic crc_err, crc_err_luma, crc_err_chroma;
    logic [4:0] ff_flags, ap_flags, anc_flags;
    logic ff_flag_err, ap_flag_err, anc_flag_err, cksum_err;
    logic fifo_empty, fifo_90, fifo_full, fifo_overrun;
    logic full_msg_avail, short_msg;
    logic [4:0] format;
    logic h, v, f, new_sync_position, sav, eav, lock, pass_fail;
  } stat_s;

  typedef struct packed {
    logic crc_replace, edh_force, edh_enable, cksum_force;
    logic [15:0] anc_id, anc_mask;
    logic message_tracking, msg_flush_static, fifo_flush_static;
    logic fifo_clk_en, fifo_extract_en;
    logic [2:0] vfifo_depth;
    logic [4:0] format_set;
    logic sd_only, hd_only, framing_mode, framing_enable;
    logic descramble_en, nrzi_en, lsb_clip_en, sync_detect_en;
    logic hdither_en, vdither_en, unscrambled_out, ext_vclk;
    logic [5:0] tpg_sel;
    logic tpg_en, bar_filter_enable;
    logic [1:0] ref_clk_sel;
  } ctrl_s;

  typedef struct packed {
    ctrl_s cfg;
    ctrl_s ctl_out;
    logic [NPIN*PCFG_W-1:0] pincfg;
    stat_s stat;
    logic [NPIN-1:0] mio_s1, mio_s2, mio_out, mio_oe_b;
    logic mrst_s1, mrst_s2;
    logic pready, pslverr;
    logic [31:0] prdata;
  } state_s;

  localparam ctrl_s CTRL_RST = '{anc_mask: 16'hffff, edh_enable: 1'b1, framing_mode: 1'b1,
    framing_enable: 1'b1, descramble_en: 1'b1, nrzi_en: 1'b1, lsb_clip_en: 1'b1,
    sync_detect_en: 1'b1, default: '0};
  localparam stat_s STAT_RST = '{fifo_empty: 1'b1, default: '0};
  // pin n drives output select n after reset
  localparam logic [NPIN*PCFG_W-1:0] PINCFG_RST =
    {6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};
  localparam state_s STATE_RST = '{cfg: CTRL_RST, ctl_out: CTRL_RST,
    pincfg: PINCFG_RST, stat: STAT_RST, default: '0};
endpackage : cfgbank_pkg
`default_nettype wire

// >>> tb/cfgbank_host.sv
// apb master standing in for the host controller of the configuration bank
// assumes one clock shared with the bank; the bench calls xfer for every access
`default_nettype none
module cfgbank_host (
  // clock
  input wire logic clk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [cfgbank_pkg::APB_AW-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfgbank_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
  end
  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no wait length assumed; the bench watchdog ends a lost answer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : cfgbank_host
`default_nettype wire

// >>> tb/video_deserializer_config_regs_test.sv
// self-checking bench of the configuration bank against a register model
// assumes cfgbank_host as the apb master and status driven straight by the bench
`default_nettype none
module video_deserializer_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cfgbank_pkg::*;
  logic CLK_SYS = 1'b0;
  logic RST_B, MAN_RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
  logic [APB_AW-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  stat_s STATUS_IN, st;
  ctrl_s CTRL_OUT;
  logic [7:0] MIO_IN, MIO_OUT, MIO_OE_B;
  logic [7:0] mdl [256];
  logic [8:0] cv, dflt;
  int fails, cmp_count;
  logic [7:0] rlist [15] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h17, 8'h18};

  video_deserializer_config_regs u_dut (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
    .MAN_RESET(MAN_RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .STATUS_IN(STATUS_IN), .CTRL_OUT(CTRL_OUT), .MIO_IN(MIO_IN), .MIO_OUT(MIO_OUT),
    .MIO_OE_B(MIO_OE_B));
  cfgbank_host u_host (.clk(CLK_SYS), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
    .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));

  always #5ns CLK_SYS = ~CLK_SYS;

  // ----------------------------------------------------------------
  // register model
  // ----------------------------------------------------------------
  // {writable mask, reset value}
  function automatic logic [15:0] tbl(input logic [7:0] i);
    case (i)
      8'h01: return 16'h6020;
      8'h02: return 16'h8000;
      8'h04: return 16'he100;
      8'h05, 8'h06: return 16'hff00;
      8'h07, 8'h08: return 16'hffff;
      8'h0b: return 16'hff80;
      8'h0d: return 16'h7f00;
      8'h0e: return 16'hfef0;
      8'h0f: return 16'h1f01;
      8'h17: return 16'hcb00;
      default: return (i >= 8'h20 && i < 8'h28) ? {8'h3f, i - 8'h20} : 16'h0;
    endcase
  endfunction : tbl
  function automatic logic [7:0] ro(input logic [7:0] i, input stat_s s);
    case (i)
      8'h01: return {s.crc_err, 2'b0, s.ff_flags};
      8'h02: return {1'b0, s.crc_err_luma, s.crc_err_chroma, s.ap_flags};
      8'h03: return {s.ff_flag_err, s.ap_flag_err, s.anc_flag_err, s.anc_flags};
      8'h04: return {3'b0, s.fifo_overrun, s.fifo_empty, s.fifo_full, s.cksum_err, 1'b0};
      8'h0c: return {s.f, s.v, s.h, s.format};
      8'h0d: return {s.pass_fail, 7'b0};
      8'h0e: return {7'b0, s.lock};
      8'h0f: return {s.eav, s.sav, s.new_sync_position, 5'b0};
      8'h17: return {2'b0, s.full_msg_avail, 5'b0};
      8'h18: return {s.fifo_90, s.short_msg, 6'b0};
      default: return 8'h0;
    endcase
  endfunction : ro
  // status bits in output select order
  function automatic logic [21:0] sv(input stat_s s);
    return {s.pass_fail, s.sav, s.new_sync_position, s.short_msg, s.full_msg_avail,
      s.fifo_overrun, s.fifo_full, s.fifo_90, s.cksum_err, s.anc_flag_err, s.ap_flag_err,
      s.ff_flag_err, s.crc_err_chroma, s.crc_err_luma, s.eav, s.fifo_empty, s.crc_err,
      s.lock, s.format[4], s.h, s.v, s.f};
  endfunction : sv

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic mdl_reset;
    logic [15:0] t;
    for (int i = 0; i < 256; i++) begin
      t = tbl(8'(i));
      mdl[i] = t[7:0];
    end
  endtask : mdl_reset
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [15:0] t;
    t = tbl(i);
    u_host.xfer(1'b1, {i, 2'b00}, {24'h0, d}, rd, er);
    chk(er, 1'b0);
    mdl[i] = d & t[15:8];
  endtask : wr
  task automatic rchk(input logic [7:0] i);
    u_host.xfer(1'b0, {i, 2'b00}, 32'h0, rd, er);
    chk({er, rd}, {9'h0, mdl[i] | ro(i, st)});
  endtask : rchk
  // status held steady long enough for the mirror and the pins to settle
  task automatic new_stat;
    logic [63:0] r;
    r = {$urandom, $urandom};
    st = r[$bits(stat_s)-1:0];
    @(posedge CLK_SYS);
    STATUS_IN <= st;
    repeat (3) @(posedge CLK_SYS);
  endtask : new_stat
  task automatic pin_chk;
    logic [21:0] s22;
    logic [7:0] oe, v;
    s22 = sv(st);
    for (int n = 0; n < 8; n++) begin
      oe[n] = mdl[32+n][5];
      v[n] = !oe[n] && s22[mdl[32+n][4:0]];
    end
    chk(MIO_OE_B, oe);
    chk(MIO_OUT & ~oe, v);
  endtask : pin_chk
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(26));
    RST_B = 1'b0;
    MAN_RESET = 1'b0;
    STATUS_IN = '0;
    MIO_IN = 8'h0;
    st = '0;
    dflt = 9'b000010010;
    mdl_reset();
    repeat (12) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    new_stat();
    foreach (rlist[k]) rchk(rlist[k]);
    for (int n = 0; n < 8; n++) rchk(8'(8'h20 + n));
    pin_chk();
    // read-only bits must ignore writes and keep mirroring status
    repeat (2) begin
      foreach (rlist[k]) wr(rlist[k], 8'($urandom));
      new_stat();
      foreach (rlist[k]) rchk(rlist[k]);
    end
    chk({CTRL_OUT.anc_id, CTRL_OUT.anc_mask, CTRL_OUT.tpg_sel, CTRL_OUT.ref_clk_sel},
      {mdl[6], mdl[5], mdl[8], mdl[7], mdl[13][5:0], mdl[15][4:3]});
    u_host.xfer(1'b0, {8'h10, 2'b00}, 32'h0, rd, er);
    chk({er, rd}, 33'h100000000);
    u_host.xfer(1'b1, {8'h05, 2'b10}, 32'hff, rd, er);
    chk(er, 1'b1);
    rchk(8'h05);
    for (int c = 0; c < 22; c++) begin
      wr(8'(8'h20 + c % 8), 8'(c));
      new_stat();
      pin_chk();
    end
    @(posedge CLK_SYS);
    MAN_RESET <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    MAN_RESET <= 1'b0;
    repeat (6) @(posedge CLK_SYS);
    mdl_reset();
    foreach (rlist[k]) rchk(rlist[k]);
    chk(CTRL_OUT, CTRL_RST);
    // every input select drives its control against the stored value
    for (int c = 0; c < 9; c++) begin
      wr(8'h20, 8'(8'h20 | c));
      MIO_IN <= {7'h0, ~dflt[c]};
      repeat (5) @(posedge CLK_SYS);
      cv = {CTRL_OUT.bar_filter_enable, CTRL_OUT.tpg_en, CTRL_OUT.vdither_en,
        CTRL_OUT.hdither_en, CTRL_OUT.framing_enable, CTRL_OUT.fifo_extract_en,
        CTRL_OUT.cksum_force, CTRL_OUT.edh_enable, CTRL_OUT.edh_force};
      chk(cv, dflt ^ (9'h1 << c));
      pin_chk();
    end
    wr(8'h20, 8'h00);
    repeat (5) @(posedge CLK_SYS);
    chk(CTRL_OUT, CTRL_RST);
    end_sim();
  end

  initial begin
    #200us;
    fails++;
    end_sim();
  end
endmodule : video_deserializer_config_regs_test
`default_nettype wire
